// ==== core/i2c_slave_params.svh ====
`ifndef I2C_SLAVE_PARAMS_SVH
`define I2C_SLAVE_PARAMS_SVH
// What this block does
// - after an acked general-call byte post E0h; next byte acked per acknowledge_enable
// - general-call byte nacked: post E8h, leave addressed mode, no recognition if disabled
// - E8h with acknowledge_enable set: own address, and general call if enabled, recognized
// - begin request set, halt request clear at E8h: generate START once bus free
// - STOP or repeated START while addressed receiver: post A0h, leave addressed mode
// - own address with read bit: transmitter mode, done flag set, interrupt low, A8h
// - addressed for read after lost arbitration: transmitter mode with status B0h
// - acknowledge_enable cleared while transmitting: current byte is last, post C8h
// - after the last byte the data line is released so master reads ones
// - acknowledge_enable clear ignores own address; setting it restores recognition anytime
// - acknowledge_enable cleared while receiving: next data byte gets a NACK

// =====================================================================
// register byte offsets
`define REG_STATUS     5'h00
`define REG_DATA       5'h04
`define REG_CONTROL    5'h08
`define REG_OWN_ADDR   5'h0c
`define REG_IRQ_STAT   5'h10
`define REG_IRQ_MASK   5'h14

// =====================================================================
// control and own address register fields and reset values
`define CTL_ACK_EN     7
`define CTL_IF_EN      6
`define CTL_BEGIN      5
`define CTL_HALT       4
`define CTL_DONE       3
`define CONTROL_RESET  8'h00
`define OWN_ADDR_RESET 8'h00
`define OWN_GC_EN      0

// =====================================================================
// status codes
`define ST_IDLE        8'hf8
`define ST_START_SENT  8'h08
`define ST_OWN_W       8'h60
`define ST_ARB_OWN_W   8'h68
`define ST_GC          8'hd0
`define ST_ARB_GC      8'hd8
`define ST_RX_ACK      8'h80
`define ST_RX_NACK     8'h88
`define ST_GC_ACK      8'he0
`define ST_GC_NACK     8'he8
`define ST_STOP_RX     8'ha0
`define ST_OWN_R       8'ha8
`define ST_ARB_OWN_R   8'hb0
`define ST_TX_ACK      8'hb8
`define ST_TX_NACK     8'hc0
`define ST_TX_LAST     8'hc8

// =====================================================================
// interrupt status bits
`define IRQ_DONE       0
`define IRQ_STOP       1
`define IRQ_SENT       2
`define IRQ_BITS       3

// =====================================================================
// timing
`define CLK_PERIOD_NS  25
`define T_HD_START_NS  600
`define START_HOLD_CYC ((`T_HD_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== core/i2c_slave_pkg.sv ====
package i2c_slave_pkg;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic bus_free;
    logic sda;
  } line_events_t;

  typedef enum logic [3:0] {
    S_IDLE      = 4'h0,
    S_ADDR      = 4'h1,
    S_ADDR_ACK  = 4'h2,
    S_RX        = 4'h3,
    S_RX_ACK    = 4'h4,
    S_TX        = 4'h5,
    S_TX_ACK    = 4'h6,
    S_HOLD      = 4'h7,
    S_START_GEN = 4'h8
  } slave_state_t;

endpackage : i2c_slave_pkg

// ==== core/line_monitor.sv ====
`timescale 1ns/1ps
module line_monitor
(
  input  wire logic                 clk_i,    // system clock
  input  wire logic                 rst_n_i,  // sync reset, active low
  input  wire logic                 scl_i,    // clock line level
  input  wire logic                 sda_i,    // data line level
  output i2c_slave_pkg::line_events_t ev_o    // edges and conditions
);
  import i2c_slave_pkg::*;

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_q_reg;
  logic       sda_q_reg;
  logic       free_reg;

  // =====================================================================
  // two-flop synchronisers, then one more stage for edges
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_q_reg    <= 1'b1;
      sda_q_reg    <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_q_reg    <= scl_sync_reg[1];
      sda_q_reg    <= sda_sync_reg[1];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      free_reg <= 1'b1;
    else if (ev_o.stop)
      free_reg <= 1'b1;
    else if (ev_o.start)
      free_reg <= 1'b0;
  end

  assign ev_o.scl_rise = scl_sync_reg[1] & ~scl_q_reg;
  assign ev_o.scl_fall = ~scl_sync_reg[1] & scl_q_reg;
  assign ev_o.start    = scl_sync_reg[1] & scl_q_reg & sda_q_reg & ~sda_sync_reg[1];
  assign ev_o.stop     = scl_sync_reg[1] & scl_q_reg & ~sda_q_reg & sda_sync_reg[1];
  assign ev_o.bus_free = free_reg;
  assign ev_o.sda      = sda_sync_reg[1];

endmodule : line_monitor

// ==== core/irq_block.sv ====
`timescale 1ns/1ps
module irq_block
#(
  parameter int unsigned N = 3
)
(
  input  wire logic         clk_i,      // system clock
  input  wire logic         rst_n_i,    // sync reset, active low
  input  wire logic [N-1:0] event_i,    // one-cycle event pulses
  input  wire logic         wr_stat_i,  // write-one-to-clear strobe
  input  wire logic         wr_mask_i,  // mask write strobe
  input  wire logic [N-1:0] wdata_i,    // write data
  output logic      [N-1:0] stat_o,     // sticky status
  output logic      [N-1:0] mask_o,     // mask
  output logic              irq_o       // level interrupt
);

  // =====================================================================
  // sticky bits; an event in the clearing cycle survives
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      stat_o <= '0;
      mask_o <= '0;
      irq_o  <= 1'b0;
    end
    else
    begin
      stat_o <= (stat_o & ~(wr_stat_i ? wdata_i : '0)) | event_i;
      if (wr_mask_i)
        mask_o <= wdata_i;
      irq_o  <= |(stat_o & mask_o);
    end
  end

endmodule : irq_block

// ==== core/i2c_slave_byte_fsm.sv ====
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "i2c_slave_params.svh"
module i2c_slave_byte_fsm
#(
  parameter int unsigned START_HOLD_CYC = `START_HOLD_CYC
)
(
  input  wire logic        clk_i,              // system clock, 40 MHz
  input  wire logic        rst_n_i,            // sync reset, active low
  input  wire logic [4:0]  avs_address_i,      // byte address
  input  wire logic        avs_read_i,         // read request
  input  wire logic        avs_write_i,        // write request
  input  wire logic [31:0] avs_writedata_i,    // write data
  input  wire logic [3:0]  avs_byteenable_i,   // byte lanes
  output logic      [31:0] avs_readdata_o,     // read data
  output logic             avs_waitrequest_o,  // stall
  input  wire logic        scl_i,              // clock line in
  input  wire logic        sda_i,              // data line in
  output logic             scl_o,              // clock line out, always low
  output logic             scl_oe_o,           // hold clock low
  output logic             sda_o,              // data line out, always low
  output logic             sda_oe_o,           // pull data low
  input  wire logic        arb_lost_i,         // master logic lost arbitration
  output logic             int_n_o,            // low while done flag set
  output logic             irq_o               // masked interrupt level
);
  import i2c_slave_pkg::*;

  line_events_t          ev;
  slave_state_t          state_reg;
  logic [7:0]            status_reg;
  logic [7:0]            data_reg;
  logic [7:0]            ctrl_reg;
  logic [7:0]            own_reg;
  logic [7:0]            shift_reg;
  logic [3:0]            bit_cnt_reg;
  logic [7:0]            hold_cnt_reg;
  logic                  si_reg;
  logic                  gc_mode_reg;
  logic                  dir_reg;
  logic                  arb_reg;
  logic                  ack_plan_reg;
  logic                  last_reg;
  logic                  rx_addr_reg;
  logic                  start_pend_reg;
  logic                  done_ev_reg;
  logic                  stop_ev_reg;
  logic                  sent_ev_reg;
  logic                  wait_reg;
  logic                  acc;
  logic                  wr_lo;
  logic                  host_clr_si;
  logic                  aa;
  logic                  own_hit;
  logic                  gc_hit;
  logic [`IRQ_BITS-1:0]  irq_stat;
  logic [`IRQ_BITS-1:0]  irq_mask;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction : hit

  // =====================================================================
  // submodules
  line_monitor u_mon
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .ev_o    (ev)
  );

  irq_block #(.N(`IRQ_BITS)) u_irq
  (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .event_i   ({sent_ev_reg, stop_ev_reg, done_ev_reg}),
    .wr_stat_i (wr_lo && hit(avs_address_i, `REG_IRQ_STAT)),
    .wr_mask_i (wr_lo && hit(avs_address_i, `REG_IRQ_MASK)),
    .wdata_i   (avs_writedata_i[`IRQ_BITS-1:0]),
    .stat_o    (irq_stat),
    .mask_o    (irq_mask),
    .irq_o     (irq_o)
  );

  // =====================================================================
  // bus slave: one wait cycle, then the access completes
  assign acc         = (avs_read_i || avs_write_i) && !wait_reg;
  assign wr_lo       = acc && avs_write_i && avs_byteenable_i[0];
  assign host_clr_si = wr_lo && hit(avs_address_i, `REG_CONTROL) && !avs_writedata_i[`CTL_DONE];
  assign aa          = ctrl_reg[`CTL_ACK_EN];
  assign avs_waitrequest_o = wait_reg;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wait_reg       <= 1'b1;
      avs_readdata_o <= 32'h0;
    end
    else if ((avs_read_i || avs_write_i) && wait_reg)
    begin
      wait_reg <= 1'b0;
      unique case (avs_address_i)
        `REG_STATUS:   avs_readdata_o <= {24'h0, status_reg};
        `REG_DATA:     avs_readdata_o <= {24'h0, data_reg};
        `REG_CONTROL:  avs_readdata_o <= {24'h0, ctrl_reg[7:4], si_reg, ctrl_reg[2:0]};
        `REG_OWN_ADDR: avs_readdata_o <= {24'h0, own_reg};
        `REG_IRQ_STAT: avs_readdata_o <= {29'h0, irq_stat};
        `REG_IRQ_MASK: avs_readdata_o <= {29'h0, irq_mask};
        default:       avs_readdata_o <= 32'h0;
      endcase
    end
    else
      wait_reg <= 1'b1;
  end

  // done bit lives with the state machine; software may only clear it
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg <= `CONTROL_RESET;
      own_reg  <= `OWN_ADDR_RESET;
    end
    else if (wr_lo)
    begin
      if (hit(avs_address_i, `REG_CONTROL))
        ctrl_reg <= avs_writedata_i[7:0] & ~(8'h1 << `CTL_DONE);
      if (hit(avs_address_i, `REG_OWN_ADDR))
        own_reg <= avs_writedata_i[7:0];
    end
  end

  // =====================================================================
  // address match; acknowledge enable gates both kinds
  assign own_hit = aa && (shift_reg[7:1] == own_reg[7:1]) && (shift_reg != 8'h00);
  assign gc_hit  = aa && own_reg[`OWN_GC_EN] && (shift_reg == 8'h00);

  // =====================================================================
  // pin outputs
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      scl_o   <= 1'b0;
      sda_o   <= 1'b0;
      int_n_o <= 1'b1;
    end
    else
    begin
      scl_o   <= 1'b0;
      sda_o   <= 1'b0;
      int_n_o <= !si_reg;
    end
  end

  // =====================================================================
  // byte-mode slave state machine
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !ctrl_reg[`CTL_IF_EN])
    begin
      state_reg      <= S_IDLE;
      status_reg     <= `ST_IDLE;
      data_reg       <= 8'h00;
      shift_reg      <= 8'h00;
      bit_cnt_reg    <= 4'h0;
      hold_cnt_reg   <= 8'h00;
      si_reg         <= 1'b0;
      gc_mode_reg    <= 1'b0;
      dir_reg        <= 1'b0;
      arb_reg        <= 1'b0;
      ack_plan_reg   <= 1'b0;
      last_reg       <= 1'b0;
      rx_addr_reg    <= 1'b0;
      start_pend_reg <= 1'b0;
      done_ev_reg    <= 1'b0;
      stop_ev_reg    <= 1'b0;
      sent_ev_reg    <= 1'b0;
      scl_oe_o       <= 1'b0;
      sda_oe_o       <= 1'b0;
    end
    else
    begin
      done_ev_reg <= 1'b0;
      stop_ev_reg <= 1'b0;
      sent_ev_reg <= 1'b0;
      if (arb_lost_i)
        arb_reg <= 1'b1;
      if (host_clr_si)
        si_reg <= 1'b0;
      if (wr_lo && hit(avs_address_i, `REG_DATA))
        data_reg <= avs_writedata_i[7:0];

      unique case (state_reg)
        S_IDLE:
        begin
          if (start_pend_reg && ev.bus_free)
          begin
            state_reg    <= S_START_GEN;
            sda_oe_o     <= 1'b1;
            hold_cnt_reg <= 8'h00;
          end
        end
        S_START_GEN:
        begin
          hold_cnt_reg <= hold_cnt_reg + 8'h01;
          if (hold_cnt_reg == 8'(START_HOLD_CYC - 1))
          begin
            // no master engine here: the line is handed back at once
            sda_oe_o       <= 1'b0;
            start_pend_reg <= 1'b0;
            status_reg     <= `ST_START_SENT;
            si_reg         <= 1'b1;
            done_ev_reg    <= 1'b1;
            sent_ev_reg    <= 1'b1;
            state_reg      <= S_HOLD;
          end
        end
        S_ADDR, S_RX:
        begin
          if (ev.scl_rise)
          begin
            shift_reg   <= {shift_reg[6:0], ev.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (ev.scl_fall && bit_cnt_reg == 4'h8)
          begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == S_RX)
            begin
              sda_oe_o  <= ack_plan_reg;
              state_reg <= S_RX_ACK;
            end
            else if (own_hit || gc_hit)
            begin
              sda_oe_o    <= 1'b1;
              gc_mode_reg <= gc_hit;
              dir_reg     <= shift_reg[0];
              state_reg   <= S_ADDR_ACK;
            end
            else
              state_reg <= S_IDLE;
          end
        end
        S_ADDR_ACK:
        begin
          if (ev.scl_fall)
          begin
            sda_oe_o    <= 1'b0;
            scl_oe_o    <= 1'b1;
            si_reg      <= 1'b1;
            done_ev_reg <= 1'b1;
            arb_reg     <= 1'b0;
            state_reg   <= S_HOLD;
            rx_addr_reg <= !dir_reg;
            if (dir_reg)
              status_reg <= arb_reg ? `ST_ARB_OWN_R : `ST_OWN_R;
            else if (gc_mode_reg)
              status_reg <= arb_reg ? `ST_ARB_GC : `ST_GC;
            else
              status_reg <= arb_reg ? `ST_ARB_OWN_W : `ST_OWN_W;
          end
        end
        S_RX_ACK:
        begin
          if (ev.scl_fall)
          begin
            sda_oe_o    <= 1'b0;
            data_reg    <= shift_reg;
            scl_oe_o    <= 1'b1;
            si_reg      <= 1'b1;
            done_ev_reg <= 1'b1;
            rx_addr_reg <= ack_plan_reg;
            state_reg   <= S_HOLD;
            if (gc_mode_reg)
              status_reg <= ack_plan_reg ? `ST_GC_ACK : `ST_GC_NACK;
            else
              status_reg <= ack_plan_reg ? `ST_RX_ACK : `ST_RX_NACK;
          end
        end
        S_TX:
        begin
          if (ev.scl_fall)
          begin
            if (bit_cnt_reg == 4'h7)
            begin
              sda_oe_o    <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg   <= S_TX_ACK;
            end
            else
            begin
              shift_reg   <= {shift_reg[6:0], 1'b0};
              sda_oe_o    <= !shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        S_TX_ACK:
        begin
          if (ev.scl_rise)
            ack_plan_reg <= !ev.sda;
          else if (ev.scl_fall)
          begin
            si_reg      <= 1'b1;
            done_ev_reg <= 1'b1;
            state_reg   <= S_HOLD;
            if (!ack_plan_reg)
              status_reg <= `ST_TX_NACK;
            else if (last_reg)
              status_reg <= `ST_TX_LAST;
            else
            begin
              status_reg <= `ST_TX_ACK;
              scl_oe_o   <= 1'b1;
            end
          end
        end
        S_HOLD:
        begin
          // the line stays released here, so a reader past the end sees ones
          if (!si_reg)
          begin
            scl_oe_o    <= 1'b0;
            bit_cnt_reg <= 4'h0;
            unique case (status_reg)
              `ST_OWN_W, `ST_ARB_OWN_W, `ST_GC, `ST_ARB_GC, `ST_RX_ACK, `ST_GC_ACK:
              begin
                ack_plan_reg <= aa;
                state_reg    <= S_RX;
              end
              `ST_OWN_R, `ST_ARB_OWN_R, `ST_TX_ACK:
              begin
                shift_reg <= data_reg;
                sda_oe_o  <= !data_reg[7];
                last_reg  <= !aa;
                state_reg <= S_TX;
              end
              default:
              begin
                rx_addr_reg    <= 1'b0;
                sda_oe_o       <= 1'b0;
                state_reg      <= S_IDLE;
                start_pend_reg <= ctrl_reg[`CTL_BEGIN] &&
                                  (status_reg != `ST_GC_NACK || !ctrl_reg[`CTL_HALT]);
              end
            endcase
          end
        end
        default:
          state_reg <= S_IDLE;
      endcase

      // conditions on the bus override the byte engine, except while it generates a START
      if ((ev.start || ev.stop) && state_reg != S_START_GEN)
      begin
        sda_oe_o    <= 1'b0;
        scl_oe_o    <= 1'b0;
        bit_cnt_reg <= 4'h0;
        shift_reg   <= 8'h00;
        if (ev.stop)
          stop_ev_reg <= 1'b1;
        if (rx_addr_reg)
        begin
          status_reg  <= `ST_STOP_RX;
          si_reg      <= 1'b1;
          done_ev_reg <= 1'b1;
          rx_addr_reg <= 1'b0;
        end
        if (ev.start)
          state_reg <= S_ADDR;
        else if (rx_addr_reg || state_reg == S_HOLD)
          state_reg <= S_HOLD;
        else
          state_reg <= S_IDLE;
      end
    end
  end

endmodule : i2c_slave_byte_fsm

// ==== verification/i2c_slave_byte_fsm_props.sv ====
`timescale 1ns/1ps
module i2c_slave_byte_fsm_props
(
  input wire logic        clk_i,             // clock
  input wire logic        rst_n_i,           // reset, low
  input wire logic [4:0]  avs_address_i,     // address
  input wire logic        avs_read_i,        // read
  input wire logic        avs_write_i,       // write
  input wire logic [31:0] avs_writedata_i,   // write data
  input wire logic [3:0]  avs_byteenable_i,  // lanes
  input wire logic        avs_waitrequest_o, // stall
  input wire logic        scl_o,             // clock out
  input wire logic        sda_o,             // data out
  input wire logic        scl_oe_o,          // stretch
  input wire logic        sda_oe_o,          // data pull
  input wire logic        int_n_o,           // done, low
  input wire logic        irq_o              // interrupt
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ==========
  // register bus
  property p_wait_answer;
    $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer");
  property p_wait_pulse;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("answer too long");
  property p_reset_idle;
    $rose(rst_n_i) |-> int_n_o && !irq_o && !scl_oe_o && avs_waitrequest_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
  // ==========
  // done flag and line hold
  property p_int_clear;
    $rose(int_n_o) |-> $past(avs_write_i, 2) && $past(avs_address_i, 2) == 5'h08;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("done cleared without write");
  property p_stretch_int;
    $rose(scl_oe_o) |-> ##[0:2] !int_n_o;
  endproperty
  a_stretch_int: assert property (p_stretch_int) else $error("hold without done");
  property p_hold_release;
    $fell(scl_oe_o) |-> $past(avs_write_i) || $past(avs_write_i, 2) || $past(avs_write_i, 3);
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("hold dropped alone");
  property p_open_drain;
    scl_o == 1'b0 && sda_o == 1'b0 && ($fell(int_n_o) -> !sda_oe_o);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_irq_masked;
    avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h14 && avs_byteenable_i[0]
      && avs_writedata_i[2:0] == 3'h0 |-> ##2 !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked irq high");
endmodule : i2c_slave_byte_fsm_props

bind i2c_slave_byte_fsm i2c_slave_byte_fsm_props u_props
(
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o), .scl_o(scl_o), .sda_o(sda_o), .scl_oe_o(scl_oe_o),
  .sda_oe_o(sda_oe_o), .int_n_o(int_n_o), .irq_o(irq_o)
);

// ==== verification/i2c_bus_master_model.sv ====
`timescale 1ns/1ps
module i2c_bus_master_model
(
  input  wire logic clk_i,     // system clock
  input  wire logic scl_i,     // resolved clock line
  input  wire logic sda_i,     // resolved data line
  output logic      scl_low_o, // pull clock low
  output logic      sda_low_o  // pull data low
);
  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // ==========
  // bit timing, 200 ns link period
  task automatic hp;
    repeat (4) @(posedge clk_i);
  endtask : hp
  task automatic bitc(input logic d, output logic s);
    int n;
    n = 0;
    repeat (2) @(posedge clk_i);
    sda_low_o <= ~d;
    repeat (2) @(posedge clk_i);
    scl_low_o <= 1'b0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (scl_i !== 1'b1 && n < 100);
    repeat (3) @(posedge clk_i);
    s = (scl_i === 1'b1) ? sda_i : 1'bx;
    scl_low_o <= 1'b1;
  endtask : bitc
  // ==========
  // frames
  task automatic start_c;
    sda_low_o <= 1'b0;
    hp();
    scl_low_o <= 1'b0;
    hp();
    sda_low_o <= 1'b1;
    hp();
    scl_low_o <= 1'b1;
  endtask : start_c
  task automatic stop_c;
    sda_low_o <= 1'b1;
    hp();
    scl_low_o <= 1'b0;
    hp();
    sda_low_o <= 1'b0;
    hp();
  endtask : stop_c
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitc(b[i], s);
    end
    bitc(1'b1, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 0; i < 8; i++)
    begin
      bitc(1'b1, s);
      b = {b[6:0], s};
    end
    bitc(nack, s);
  endtask : rbyte
endmodule : i2c_bus_master_model

// ==== verification/test_i2c_slave_byte_fsm.sv ====
`timescale 1ns/1ps
module test_i2c_slave_byte_fsm;
  import i2c_slave_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o, scl_o, sda_o, scl_oe_o, sda_oe_o, int_n_o, irq_o;
  logic        arb_lost_i = 1'b0;
  logic        scl_pull, sda_pull;
  wire         scl_line = ~(scl_oe_o | scl_pull);
  wire         sda_line = ~(sda_oe_o | sda_pull);
  int          miscompares = 0;
  int          compares = 0;
  always #12.5 clk_i = ~clk_i;
  i2c_slave_byte_fsm #(.START_HOLD_CYC(4)) DUT
  (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .scl_i(scl_line),
    .sda_i(sda_line), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .arb_lost_i(arb_lost_i), .int_n_o(int_n_o), .irq_o(irq_o)
  );
  i2c_bus_master_model mst
  (
    .clk_i(clk_i), .scl_i(scl_line), .sda_i(sda_line), .scl_low_o(scl_pull), .sda_low_o(sda_pull)
  );
  // ==========
  // checking
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic timeout(input string what);
    miscompares++;
    $display("BAD %0t no %s", $time, what);
    summarize();
  endtask : timeout
  // ==========
  // register bus, one request held until waitrequest low
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= ~w;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 20)
      timeout("bus answer");
    repeat (2) @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk(q, e);
  endtask : rd
  // ==========
  // serial steps; status 00 means none expected
  task automatic wait_for(input logic start_gen);
    int n;
    n = 0;
    while ((start_gen ? sda_oe_o !== 1'b1 : int_n_o !== 1'b0) && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000)
      timeout("line event");
  endtask : wait_for
  task automatic post(input logic [7:0] st);
    if (st != 8'h00)
    begin
      wait_for(1'b0);
      rd(5'h00, st);
    end
  endtask : post
  task automatic tx(input logic [7:0] b, input logic ak, input logic [7:0] st);
    logic a;
    mst.wbyte(b, a);
    chk(8'(a), 8'(ak));
    post(st);
  endtask : tx
  task automatic rx(input logic nk, input logic [7:0] e, input logic [7:0] st);
    logic [7:0] b;
    mst.rbyte(nk, b);
    chk(b, e);
    post(st);
  endtask : rx
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(5'h00, 8'hf8);
    rd(5'h18, 8'h00);
    wr(5'h0c, 8'ha1);
    wr(5'h08, 8'hc0);
    wr(5'h14, 8'h01);
    mst.start_c();
    tx(8'ha1, 1'b1, 8'ha8);
    chk(8'(int_n_o), 8'h00);
    chk(8'(irq_o), 8'h01);
    wr(5'h14, 8'h00);
    chk(8'(irq_o), 8'h00);
    wr(5'h10, 8'h07);
    wr(5'h14, 8'h01);
    chk(8'(irq_o), 8'h00);
    wr(5'h04, 8'ha5);
    wr(5'h08, 8'hc0);
    rx(1'b0, 8'ha5, 8'hb8);
    wr(5'h04, 8'h3c);
    wr(5'h08, 8'h40);
    rx(1'b0, 8'h3c, 8'hc8);
    rx(1'b1, 8'hff, 8'h00);
    mst.stop_c();
    wr(5'h08, 8'hc0);
    arb_lost_i <= 1'b1;
    @(posedge clk_i);
    arb_lost_i <= 1'b0;
    mst.start_c();
    tx(8'ha1, 1'b1, 8'hb0);
    wr(5'h04, 8'h81);
    wr(5'h08, 8'hc0);
    rx(1'b1, 8'h81, 8'hc0);
    mst.stop_c();
    wr(5'h08, 8'hc0);
    mst.start_c();
    tx(8'ha0, 1'b1, 8'h60);
    wr(5'h08, 8'hc0);
    tx(8'h5a, 1'b1, 8'h80);
    rd(5'h04, 8'h5a);
    wr(5'h08, 8'hc0);
    mst.stop_c();
    post(8'ha0);
    wr(5'h08, 8'hc0);
    mst.start_c();
    tx(8'h00, 1'b1, 8'hd0);
    wr(5'h08, 8'hc0);
    tx(8'h11, 1'b1, 8'he0);
    wr(5'h08, 8'h40);
    tx(8'h22, 1'b0, 8'he8);
    wr(5'h08, 8'h60);
    mst.start_c();
    tx(8'ha0, 1'b0, 8'h00);
    mst.stop_c();
    wait_for(1'b1);
    chk(8'(scl_line), 8'h01);
    post(8'h08);
    rd(5'h10, 8'h07);
    summarize();
  end
endmodule : test_i2c_slave_byte_fsm
